// ==== eeprom_pkg.sv ====
/*
 * constants shared by the serial eeprom device: frame layout, opcodes,
 * reset values and the self-timed programming bound.
 * assumes a 25 MHz core clock and a host that frames commands with chip select.
 */
package eeprom_pkg;

	localparam int CLK_PERIOD_NS = 40;
	localparam int ADDR_W        = 9;
	localparam int WORD_W        = 16;
	localparam int DEPTH         = 512;

	// frame: 8 opcode bits, 8 address bits, then 16 data bits
	localparam logic [5:0] OPADDR_BITS = 6'h10;
	localparam logic [5:0] FRAME_BITS  = 6'h20;

	// 7-bit prefixes; opcode bit 0 carries the top (or bottom) address bit
	localparam logic [6:0] OP_READ_PFX  = 7'h54;
	localparam logic [6:0] OP_WRITE_PFX = 7'h52;
	localparam logic [7:0] OP_PROG_EN   = 8'hA3;
	localparam logic [7:0] OP_PROG_DIS  = 8'hA0;

	localparam int PROG_TIME_MS = 5;
	// longest time rounds down
	localparam int PROG_CYCLES  = (PROG_TIME_MS * 1000000) / CLK_PERIOD_NS;

	localparam logic       PROG_EN_RST  = 1'b0;
	localparam logic       PIN_IDLE_HI  = 1'b1;
	localparam logic [3:0] BIT_IDX_RST  = 4'h0;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_CMD  = 2'b01,
		ST_READ = 2'b11,
		ST_DATA = 2'b10
	} frame_state_e;

endpackage

// ==== pin_sync.sv ====
/*
 * three-flop synchroniser for one pin; the output level changes only once
 * the second and third stages agree.
 * assumes the pin is asynchronous to core_clk_in.
 */
`timescale 1ns/1ns
module pin_sync #(
	parameter logic IDLE_LEVEL = 1'b1
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic pin_in,
	output logic      level_out
);

	logic [2:0] stage_reg;

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			stage_reg <= {3{IDLE_LEVEL}};
		end else begin
			stage_reg <= {stage_reg[1:0], pin_in};
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			level_out <= IDLE_LEVEL;
		end else if (stage_reg[1] == stage_reg[2]) begin
			level_out <= stage_reg[2];
		end
	end

endmodule

// ==== serial_eeprom.sv ====
/*
 * serial eeprom device core: command shifter, sequential read, single-word
 * write with self-timed programming, and the programming enable latch.
 * assumes the host drives chip select, serial clock and data in from outside
 * the core clock domain, each at well under a quarter of 25 MHz.
 */
`timescale 1ns/1ns
module serial_eeprom #(
	parameter int   PROG_CYCLES = eeprom_pkg::PROG_CYCLES,
	parameter logic LSB_FIRST   = 1'b0
) (
	input  wire logic core_clk_in,
	input  wire logic rst_n_in,
	input  wire logic chip_select_n_in,
	input  wire logic serial_clock_in,
	input  wire logic serial_data_in,
	output logic      data_out_out,
	output logic      data_out_oe_out,
	output logic      ready_out,
	output logic      program_enabled_out
);

	localparam int AW = eeprom_pkg::ADDR_W;
	localparam int WW = eeprom_pkg::WORD_W;

	// the programming counter is 20 bits wide
	if (PROG_CYCLES < 1 || PROG_CYCLES > 1048575) begin
		$error("PROG_CYCLES out of range");
	end

	function automatic logic [AW-1:0] rev_addr(input logic [AW-1:0] a);
		logic [AW-1:0] r;
		r = '0;
		for (int i = 0; i < AW; i++) begin
			r[i] = a[AW-1-i];
		end
		return r;
	endfunction

	function automatic logic [WW-1:0] rev_word(input logic [WW-1:0] w);
		logic [WW-1:0] r;
		r = '0;
		for (int i = 0; i < WW; i++) begin
			r[i] = w[WW-1-i];
		end
		return r;
	endfunction

	logic cs_n_lvl;
	logic sk_lvl;
	logic di_lvl;
	logic cs_n_prev_reg;
	logic sk_prev_reg;

	pin_sync #(.IDLE_LEVEL(eeprom_pkg::PIN_IDLE_HI)) u_cs_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (chip_select_n_in),
		.level_out   (cs_n_lvl)
	);

	pin_sync #(.IDLE_LEVEL(eeprom_pkg::PIN_IDLE_HI)) u_sk_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (serial_clock_in),
		.level_out   (sk_lvl)
	);

	pin_sync #(.IDLE_LEVEL(1'b0)) u_di_sync (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.pin_in      (serial_data_in),
		.level_out   (di_lvl)
	);

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			cs_n_prev_reg <= eeprom_pkg::PIN_IDLE_HI;
			sk_prev_reg   <= eeprom_pkg::PIN_IDLE_HI;
		end else begin
			cs_n_prev_reg <= cs_n_lvl;
			sk_prev_reg   <= sk_lvl;
		end
	end

	logic cs_fall;
	logic sk_rise;
	logic sk_fall;
	assign cs_fall = cs_n_prev_reg && !cs_n_lvl;
	assign sk_rise = !sk_prev_reg && sk_lvl && !cs_n_lvl;
	assign sk_fall = sk_prev_reg && !sk_lvl && !cs_n_lvl;

	eeprom_pkg::frame_state_e state_reg;
	logic [5:0]    bit_cnt_reg;
	logic [23:0]   shift_reg;
	logic [AW-1:0] rd_addr_reg;
	logic [3:0]    bit_idx_reg;
	logic          prog_en_reg;
	logic          busy_reg;
	logic [19:0]   prog_cnt_reg;
	logic [AW-1:0] wr_addr_reg;
	logic [WW-1:0] wr_word_reg;
	logic [WW-1:0] mem_reg [eeprom_pkg::DEPTH];

	// opcode decodes at the 16th bit; write address and word at the 32nd,
	// when the address bits have moved up to shift_reg[23:15]
	logic [7:0]    next_op;
	logic [AW-1:0] frame_addr;
	logic [WW-1:0] frame_word;
	logic [WW-1:0] next_word;
	assign next_op    = shift_reg[14:7];
	assign frame_addr = LSB_FIRST ? rev_addr(shift_reg[23:15]) : shift_reg[23:15];
	assign next_word  = {shift_reg[14:0], di_lvl};
	assign frame_word = LSB_FIRST ? rev_word(next_word) : next_word;

	logic op_done;
	logic data_done;
	assign op_done   = sk_rise && state_reg == eeprom_pkg::ST_CMD
		&& bit_cnt_reg == eeprom_pkg::OPADDR_BITS - 6'h01;
	assign data_done = sk_rise && state_reg == eeprom_pkg::ST_DATA
		&& bit_cnt_reg == eeprom_pkg::FRAME_BITS - 6'h01;

	// frame sequencing; busy refuses new frames until programming ends
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			state_reg <= eeprom_pkg::ST_IDLE;
		end else if (cs_n_lvl) begin
			state_reg <= eeprom_pkg::ST_IDLE;
		end else begin
			case (state_reg)
				eeprom_pkg::ST_IDLE: begin
					if (cs_fall && sk_lvl && !busy_reg) begin
						state_reg <= eeprom_pkg::ST_CMD;
					end
				end
				eeprom_pkg::ST_CMD: begin
					if (op_done) begin
						if (next_op[7:1] == eeprom_pkg::OP_READ_PFX) begin
							state_reg <= eeprom_pkg::ST_READ;
						end else if (next_op[7:1] == eeprom_pkg::OP_WRITE_PFX) begin
							state_reg <= eeprom_pkg::ST_DATA;
						end else begin
							state_reg <= eeprom_pkg::ST_IDLE;
						end
					end
				end
				eeprom_pkg::ST_DATA: begin
					if (data_done) begin
						state_reg <= eeprom_pkg::ST_IDLE;
					end
				end
				eeprom_pkg::ST_READ: begin
					state_reg <= eeprom_pkg::ST_READ;
				end
				default: begin
					state_reg <= eeprom_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// bits are sampled on serial clock rising edges, MSB of opcode first
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || cs_n_lvl || state_reg == eeprom_pkg::ST_IDLE) begin
			bit_cnt_reg <= 6'h00;
			shift_reg   <= 24'h000000;
		end else if (sk_rise && bit_cnt_reg < eeprom_pkg::FRAME_BITS) begin
			bit_cnt_reg <= bit_cnt_reg + 6'h01;
			shift_reg   <= {shift_reg[22:0], di_lvl};
		end
	end

	// the opcode reaches shift_reg[15:8] on the 16th edge, so look one ahead
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			prog_en_reg <= eeprom_pkg::PROG_EN_RST;
		end else if (op_done && next_op == eeprom_pkg::OP_PROG_EN) begin
			prog_en_reg <= 1'b1;
		end else if (op_done && next_op == eeprom_pkg::OP_PROG_DIS) begin
			prog_en_reg <= 1'b0;
		end
	end

	// read pointer and bit position; latch state plays no part here
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			rd_addr_reg <= '0;
			bit_idx_reg <= eeprom_pkg::BIT_IDX_RST;
		end else if (op_done) begin
			rd_addr_reg <= LSB_FIRST ? rev_addr({next_op[0], shift_reg[6:0], di_lvl})
				: {next_op[0], shift_reg[6:0], di_lvl};
			bit_idx_reg <= eeprom_pkg::BIT_IDX_RST;
		end else if (sk_fall && state_reg == eeprom_pkg::ST_READ) begin
			bit_idx_reg <= bit_idx_reg + 4'h1;
			if (bit_idx_reg == 4'hF) begin
				rd_addr_reg <= rd_addr_reg + 9'h001;
			end
		end
	end

	// first falling edge in the read state is the 17th of the frame
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in || cs_n_lvl || state_reg != eeprom_pkg::ST_READ) begin
			data_out_oe_out <= 1'b0;
			data_out_out    <= 1'b0;
		end else if (sk_fall) begin
			data_out_oe_out <= 1'b1;
			data_out_out    <= LSB_FIRST ? mem_reg[rd_addr_reg][bit_idx_reg]
				: mem_reg[rd_addr_reg][4'hF - bit_idx_reg];
		end
	end

	// a write only arms programming with the latch set
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			busy_reg     <= 1'b0;
			prog_cnt_reg <= 20'h00000;
			wr_addr_reg  <= '0;
			wr_word_reg  <= '0;
		end else if (busy_reg) begin
			if (prog_cnt_reg == 20'(PROG_CYCLES - 1)) begin
				busy_reg <= 1'b0;
			end
			prog_cnt_reg <= prog_cnt_reg + 20'h00001;
		end else if (data_done && prog_en_reg) begin
			busy_reg     <= 1'b1;
			prog_cnt_reg <= 20'h00000;
			wr_addr_reg  <= frame_addr;
			wr_word_reg  <= frame_word;
		end
	end

	// cells change at the end of the cycle; holds old data meanwhile
	always_ff @(posedge core_clk_in) begin
		if (busy_reg && prog_cnt_reg == 20'(PROG_CYCLES - 1)) begin
			mem_reg[wr_addr_reg] <= wr_word_reg;
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			ready_out           <= 1'b1;
			program_enabled_out <= 1'b0;
		end else begin
			ready_out           <= !busy_reg;
			program_enabled_out <= prog_en_reg;
		end
	end

endmodule

// ==== eeprom_asserts.sv ====
/*
 * port checker for the serial eeprom core, bound to serial_eeprom.
 * assumes the host holds each serial clock level for at least 8 core clocks.
 */
`timescale 1ns/1ns
module eeprom_asserts #(
	parameter int PROG_CYCLES = 20
) (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic chip_select_n_in,
	input wire logic serial_clock_in,
	input wire logic serial_data_in,
	input wire logic data_out_out,
	input wire logic data_out_oe_out,
	input wire logic ready_out,
	input wire logic program_enabled_out
);
	localparam int PROG_MAX = PROG_CYCLES + 2;
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	AST_OE_RELEASE: assert property ($rose(chip_select_n_in) |-> ##[1:7] !data_out_oe_out)
		else $error("output enable held after deselect");
	AST_OE_SELECTED: assert property (data_out_oe_out |-> !$past(chip_select_n_in, 7))
		else $error("output enabled without select");
	AST_DATA_IDLE: assert property (!data_out_oe_out |-> !data_out_out)
		else $error("data active while released");
	AST_DATA_ON_FALL: assert property (data_out_oe_out && $past(data_out_oe_out)
		&& $changed(data_out_out) |-> !serial_clock_in && !$past(serial_clock_in, 3))
		else $error("read data moved off the falling clock");
	AST_FIRST_BIT: assert property ($rose(data_out_oe_out) |->
		!serial_clock_in && !$past(serial_clock_in, 3) && !chip_select_n_in)
		else $error("output enable rose off a falling clock");
	AST_NO_OE_BUSY: assert property (!ready_out |-> !data_out_oe_out)
		else $error("output driven while programming");
	AST_BUSY_NEEDS_LATCH: assert property ($fell(ready_out) |-> program_enabled_out)
		else $error("programming started with latch clear");
	AST_PROG_BOUND: assert property ($fell(ready_out) |->
		(!ready_out) [*8] ##[1:PROG_MAX] ready_out)
		else $error("programming time out of bounds");
	AST_LATCH_HOLDS: assert property ($changed(program_enabled_out) |-> !chip_select_n_in)
		else $error("latch changed outside a frame");
	cover property ($rose(data_out_oe_out));
	cover property ($fell(ready_out));
	cover property ($fell(program_enabled_out));
endmodule

bind serial_eeprom eeprom_asserts #(.PROG_CYCLES(PROG_CYCLES)) i_eeprom_asserts (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(chip_select_n_in),
	.serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in),
	.data_out_out(data_out_out), .data_out_oe_out(data_out_oe_out),
	.ready_out(ready_out), .program_enabled_out(program_enabled_out));

// ==== host_model.sv ====
/*
 * host side of the serial port: frames instructions and clocks out read data.
 * assumes core_clk_in is the device core clock; pins move at its falling edge.
 */
`timescale 1ns/1ns
module host_model (
	input  wire logic core_clk_in,
	input  wire logic data_pin_in,
	output logic      cs_n_out,
	output logic      sk_out,
	output logic      di_out
);
	initial begin
		cs_n_out = 1'b1;
		sk_out = 1'b1;
		di_out = 1'b0;
	end
	task automatic hold();
		repeat (8) @(negedge core_clk_in);
	endtask
	// sends the top nb bits msb first, then clocks nr read bits in
	task automatic frame(input logic [31:0] bits, input int nb, input int nr,
		output logic [63:0] rd);
		rd = '0;
		cs_n_out = 1'b0;
		hold();
		for (int i = 31; i > 31 - nb; i--) begin
			sk_out = 1'b0;
			di_out = bits[i];
			hold();
			sk_out = 1'b1;
			hold();
		end
		for (int i = 0; i < nr; i++) begin
			sk_out = 1'b0;
			di_out = ~di_out;
			hold();
			rd = {rd[62:0], data_pin_in};
			sk_out = 1'b1;
			hold();
		end
		cs_n_out = 1'b1;
		hold();
	endtask
endmodule

// ==== serial_eeprom_read_and_write_enable_bench.sv ====
/*
 * self-checking bench for serial_eeprom, driven through host_model.
 * assumes a shortened programming time of 20 core clocks.
 */
`timescale 1ns/1ns
module serial_eeprom_read_and_write_enable_bench;
	logic        core_clk_in, rst_n_in, cs_n, sk, di, dout, oe, ready, enabled;
	logic        data_pin;
	logic        cs2_n, sk2, di2, dout2, oe2, ready2, enabled2, data_pin2;
	logic [63:0] rd;
	int          mismatches, compares, cycles, oe_cycles, base;
	logic [24:0] rows [4] = '{{9'h000, 16'h0001}, {9'h001, 16'hC3A5},
		{9'h1FF, 16'h8000}, {9'h0AA, 16'h5A3C}};
	// a released pin wobbles so a stale level cannot pass for data
	assign data_pin = oe ? dout : cycles[0];
	serial_eeprom #(.PROG_CYCLES(20)) i_serial_eeprom (.core_clk_in(core_clk_in),
		.rst_n_in(rst_n_in), .chip_select_n_in(cs_n), .serial_clock_in(sk),
		.serial_data_in(di), .data_out_out(dout), .data_out_oe_out(oe),
		.ready_out(ready), .program_enabled_out(enabled));
	host_model i_host_model (.core_clk_in(core_clk_in), .data_pin_in(data_pin),
		.cs_n_out(cs_n), .sk_out(sk), .di_out(di));
	// second core in the bit-reversed order, with its own host
	assign data_pin2 = oe2 ? dout2 : cycles[0];
	serial_eeprom #(.PROG_CYCLES(20), .LSB_FIRST(1'b1)) i_serial_eeprom_lsb (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .chip_select_n_in(cs2_n),
		.serial_clock_in(sk2), .serial_data_in(di2), .data_out_out(dout2),
		.data_out_oe_out(oe2), .ready_out(ready2), .program_enabled_out(enabled2));
	host_model i_host_model_lsb (.core_clk_in(core_clk_in), .data_pin_in(data_pin2),
		.cs_n_out(cs2_n), .sk_out(sk2), .di_out(di2));
	// cycles in which the first core drives, sampled away from its launch edge
	always @(negedge core_clk_in) begin
		if (oe) begin
			oe_cycles++;
		end
	end
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic check_word(input string what, input logic [15:0] exp, got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic check_bit(input string what, input logic exp, got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic cmd(input logic [7:0] op);
		i_host_model.frame({op, 24'h000000}, 16, 0, rd);
	endtask
	task automatic wr(input logic [8:0] a, input logic [15:0] d);
		i_host_model.frame({eeprom_pkg::OP_WRITE_PFX, a, d}, 32, 0, rd);
	endtask
	task automatic rdw(input logic [8:0] a, input int n);
		i_host_model.frame({eeprom_pkg::OP_READ_PFX, a, 16'h0000}, 16, n, rd);
	endtask
	function automatic logic [15:0] flip16(input logic [15:0] w);
		for (int i = 0; i < 16; i++) begin
			flip16[i] = w[15 - i];
		end
	endfunction
	function automatic logic [8:0] flip9(input logic [8:0] a);
		for (int i = 0; i < 9; i++) begin
			flip9[i] = a[8 - i];
		end
	endfunction
	task automatic wr_lsb(input logic [8:0] a, input logic [15:0] d);
		i_host_model_lsb.frame({eeprom_pkg::OP_WRITE_PFX, flip9(a), flip16(d)}, 32, 0, rd);
	endtask
	task automatic wait_ready(input logic lsb);
		for (int n = 0; n < 100 && (lsb ? ready2 : ready) !== 1'b1; n++) begin
			@(negedge core_clk_in);
		end
		check_bit("ready", 1'b1, lsb ? ready2 : ready);
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #20 core_clk_in = ~core_clk_in;
	end
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles == 40000) begin
			mismatches++;
			end_of_test();
		end
	end
	initial begin
		rst_n_in = 1'b0;
		repeat (16) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check_bit("ready", 1'b1, ready);
		check_bit("enabled", 1'b0, enabled);
		check_bit("oe", 1'b0, oe);
		cmd(eeprom_pkg::OP_PROG_EN);
		check_bit("enabled", 1'b1, enabled);
		foreach (rows[i]) begin
			base = oe_cycles;
			wr(rows[i][24:16], rows[i][15:0]);
			check_bit("busy", 1'b0, ready);
			check_bit("quiet", 1'b1, oe_cycles == base);
			wait_ready(1'b0);
			rdw(rows[i][24:16], 16);
			check_word("read", rows[i][15:0], rd[15:0]);
			check_bit("oe", 1'b0, oe);
		end
		check_bit("enabled", 1'b1, enabled);
		cmd(eeprom_pkg::OP_PROG_DIS);
		check_bit("enabled", 1'b0, enabled);
		wr(9'h0AA, 16'hFFFF);
		check_bit("ready", 1'b1, ready);
		rdw(9'h0AA, 16);
		check_word("kept", 16'h5A3C, rd[15:0]);
		rdw(9'h1FF, 48);
		check_word("top", 16'h8000, rd[47:32]);
		check_word("wrap", 16'h0001, rd[31:16]);
		check_word("next", 16'hC3A5, rd[15:0]);
		i_host_model_lsb.frame({eeprom_pkg::OP_PROG_EN, 24'h000000}, 16, 0, rd);
		wr_lsb(9'h0C5, 16'h1234);
		wait_ready(1'b1);
		wr_lsb(9'h0C6, 16'hE00F);
		wait_ready(1'b1);
		i_host_model_lsb.frame({eeprom_pkg::OP_READ_PFX, flip9(9'h0C5), 16'h0000}, 16, 32, rd);
		check_word("lsb first", flip16(16'h1234), rd[31:16]);
		check_word("lsb next", flip16(16'hE00F), rd[15:0]);
		check_bit("lsb oe", 1'b0, oe2);
		cmd(eeprom_pkg::OP_PROG_EN);
		rst_n_in = 1'b0;
		repeat (6) @(negedge core_clk_in);
		rst_n_in = 1'b1;
		repeat (8) @(negedge core_clk_in);
		check_bit("enabled", 1'b0, enabled);
		check_bit("lsb enabled", 1'b0, enabled2);
		check_bit("oe", 1'b0, oe);
		end_of_test();
	end
endmodule
